// >>> core/fspc_ctrl.sv
// self-programming sequencer with its control/status register
`timescale 1ns/1ps
module fspc_ctrl #(
	parameter int PROG_CYCLES = fspc_pkg::PROG_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// cpu i/o register access
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [5:0] io_addr,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata_ff,
	// store/load program memory instructions
	input wire logic store_exec,
	input wire logic load_exec,
	input wire logic [15:0] z_ptr,
	input wire logic [7:0] r0_data,
	input wire logic [7:0] r1_data,
	input wire logic global_irq_en,
	output logic [7:0] load_data_ff,
	output logic load_hit_ff,
	// fuses and eeprom interlock
	input wire logic [1:0] boot_size_fuse,
	input wire logic [7:0] fuse_lo,
	input wire logic [7:0] fuse_hi,
	input wire logic [7:0] fuse_ext,
	input wire logic eeprom_write_active,
	// flash array side
	input wire logic [5:0] flash_buf_addr,
	output logic [15:0] flash_buf_data_ff,
	output logic flash_erase_ff,
	output logic flash_write_ff,
	output logic [7:0] page_select_field_ff,
	output logic [7:0] lock_bits_ff,
	// cpu status
	output logic ready_irq_ff,
	output logic cpu_halt_ff,
	output logic fetch_no_read_while_write_region_only_ff,
	output logic rw_region_busy_ff,
	output logic [13:0] boot_start_ff,
	output logic [11:0] boot_words_ff
);
	fspc_core_if cif ();

	// control bits
	logic irq_en_ff, nxt_irq_en;
	logic busy_ff, nxt_busy;
	logic [4:0] cmd_ff, nxt_cmd; // read_en, lock, write, erase, enable
	logic [2:0] win_ff, nxt_win;
	fspc_pkg::fspc_state_type state_ff, nxt_state;
	// operation outputs
	logic erase_ff_n, write_ff_n, halt_n, fetch_n, hit_n, irq_n;
	logic [7:0] page_n, lock_n, load_n, rdata_n, lock_data_ff, nxt_lock_data;
	logic [13:0] bstart_n;
	logic [11:0] bwords_n;
	logic [7:0] reg_view;
	logic reg_wr, armed, store_ok, load_ok, op_rww;
	logic [4:0] wpat;

	fspc_page_buffer #(.DEPTH(fspc_pkg::PAGE_WORDS)) u_buf (
		.clk(clk),
		.rst_b(rst_b),
		.bus(cif.buffer)
	);

	fspc_prog_timer #(.CYCLES(PROG_CYCLES)) u_tmr (
		.clk(clk),
		.rst_b(rst_b),
		.bus(cif.timer)
	);

	// register view; reserved bit is constant zero
	assign reg_view = {irq_en_ff, busy_ff, 1'b0, cmd_ff};
	assign reg_wr = io_wr && (io_addr == fspc_pkg::REG_ADDR);
	assign wpat = io_wdata[4:0];
	assign armed = (win_ff != 3'h0) && (state_ff == fspc_pkg::ST_IDLE);
	// store accepted through the whole four-cycle window
	assign store_ok = armed && store_exec;
	// load accepted only in the first three cycles of the window
	assign load_ok = armed && load_exec && cmd_ff[3] && (win_ff > (fspc_pkg::STORE_WIN - fspc_pkg::LOAD_WIN));
	assign op_rww = z_ptr[fspc_pkg::PTR_PAGE_MSB:fspc_pkg::PTR_PAGE_LSB] < fspc_pkg::RWW_PAGES;

	// buffer port: fill address from word field, pointer bit 0 ignored
	always_comb begin
		cif.buf_wr = store_ok && (cmd_ff == fspc_pkg::PAT_FILL);
		cif.buf_wr_addr = z_ptr[fspc_pkg::PTR_WORD_MSB:fspc_pkg::PTR_WORD_LSB];
		cif.buf_wr_data = {r1_data, r0_data};
		cif.buf_rd_addr = flash_buf_addr;
		// a written page consumes the buffer; read-enable during fill aborts it
		cif.buf_clr = (state_ff == fspc_pkg::ST_PROG && cif.tmr_done && cmd_ff[2])
			|| (reg_wr && wpat == fspc_pkg::PAT_READ_EN && cif.buf_loaded);
		cif.tmr_start = store_ok && (cmd_ff == fspc_pkg::PAT_PAGE_ERASE || cmd_ff == fspc_pkg::PAT_PAGE_WRITE
			|| cmd_ff == fspc_pkg::PAT_LOCK_SET);
	end

	// command register, window and operation sequencer
	always_comb begin
		nxt_irq_en = irq_en_ff;
		nxt_busy = busy_ff;
		nxt_cmd = cmd_ff;
		nxt_win = win_ff;
		nxt_state = state_ff;
		nxt_lock_data = lock_data_ff;
		erase_ff_n = 1'b0;
		write_ff_n = 1'b0;
		halt_n = cpu_halt_ff;
		fetch_n = fetch_no_read_while_write_region_only_ff;
		page_n = page_select_field_ff;
		lock_n = lock_bits_ff;
		// window runs down from the write cycle; expiry disarms
		if (win_ff != 3'h0) begin
			nxt_win = win_ff - 3'h1;
			if (win_ff == 3'h1 && state_ff == fspc_pkg::ST_IDLE) begin
				nxt_cmd = 5'h00;
			end
		end
		case (state_ff)
			fspc_pkg::ST_IDLE: begin
				if (store_ok) begin
					nxt_win = 3'h0;
					case (cmd_ff)
						fspc_pkg::PAT_FILL: begin
							nxt_cmd = 5'h00;
							nxt_busy = 1'b0;
						end
						fspc_pkg::PAT_READ_EN: begin
							nxt_cmd = 5'h00;
							nxt_busy = 1'b0;
						end
						fspc_pkg::PAT_LOCK_SET: begin
							nxt_state = fspc_pkg::ST_LOCK;
							nxt_lock_data = r0_data;
						end
						fspc_pkg::PAT_PAGE_ERASE, fspc_pkg::PAT_PAGE_WRITE: begin
							nxt_state = fspc_pkg::ST_PROG;
							page_n = z_ptr[fspc_pkg::PTR_PAGE_MSB:fspc_pkg::PTR_PAGE_LSB];
							erase_ff_n = cmd_ff[1];
							write_ff_n = cmd_ff[2];
							fetch_n = 1'b1;
							if (op_rww) begin
								nxt_busy = 1'b1;
							end else begin
								halt_n = 1'b1;
							end
						end
						default: begin
							nxt_cmd = 5'h00;
						end
					endcase
				end else if (load_ok) begin
					nxt_win = 3'h0;
					nxt_cmd = 5'h00;
				end
			end
			fspc_pkg::ST_PROG: begin
				// enable and command bit stay up until the timer ends
				if (cif.tmr_done) begin
					nxt_state = fspc_pkg::ST_IDLE;
					nxt_cmd = 5'h00;
					halt_n = 1'b0;
					fetch_n = 1'b0;
				end
			end
			fspc_pkg::ST_LOCK: begin
				if (cif.tmr_done) begin
					nxt_state = fspc_pkg::ST_IDLE;
					nxt_cmd = 5'h00;
					// cleared bits in the data program the lock; top two never change
					lock_n = lock_bits_ff & (lock_data_ff | fspc_pkg::LOCK_KEEP);
				end
			end
			default: begin
				nxt_state = fspc_pkg::ST_IDLE;
			end
		endcase
		// software write: interrupt enable always, command bits only when legal and idle
		if (reg_wr) begin
			nxt_irq_en = io_wdata[fspc_pkg::BIT_IRQ_EN];
			// eeprom write blocks arming, as does a running operation
			if (state_ff == fspc_pkg::ST_IDLE && !cif.tmr_busy && !eeprom_write_active
				&& (wpat == fspc_pkg::PAT_READ_EN || wpat == fspc_pkg::PAT_LOCK_SET
				|| wpat == fspc_pkg::PAT_PAGE_WRITE || wpat == fspc_pkg::PAT_PAGE_ERASE
				|| wpat == fspc_pkg::PAT_FILL)) begin
				nxt_cmd = wpat;
				nxt_win = fspc_pkg::STORE_WIN;
			end
		end
	end

	// readback, interrupt and boot decode
	always_comb begin
		rdata_n = io_rd && (io_addr == fspc_pkg::REG_ADDR) ? reg_view : 8'h00;
		hit_n = load_ok;
		load_n = load_data_ff;
		if (load_ok) begin
			case (z_ptr[1:0])
				fspc_pkg::SEL_LOCK: load_n = lock_bits_ff;
				fspc_pkg::SEL_FUSE_HI: load_n = fuse_hi;
				fspc_pkg::SEL_FUSE_EXT: load_n = fuse_ext;
				default: load_n = fuse_lo;
			endcase
		end
		// level request for as long as enable stays clear
		irq_n = irq_en_ff && global_irq_en && !nxt_cmd[fspc_pkg::BIT_ENABLE];
		case (boot_size_fuse)
			2'b11: begin
				bstart_n = fspc_pkg::BOOT_START_3;
				bwords_n = fspc_pkg::BOOT_WORDS_3;
			end
			2'b10: begin
				bstart_n = fspc_pkg::BOOT_START_2;
				bwords_n = fspc_pkg::BOOT_WORDS_2;
			end
			2'b01: begin
				bstart_n = fspc_pkg::BOOT_START_1;
				bwords_n = fspc_pkg::BOOT_WORDS_1;
			end
			default: begin
				bstart_n = fspc_pkg::BOOT_START_0;
				bwords_n = fspc_pkg::BOOT_WORDS_0;
			end
		endcase
	end

	// all state registers; reset leaves the register at zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_en_ff <= 1'b0;
			busy_ff <= 1'b0;
			cmd_ff <= 5'h00;
			win_ff <= 3'h0;
			state_ff <= fspc_pkg::ST_IDLE;
			lock_data_ff <= 8'hFF;
			io_rdata_ff <= 8'h00;
			load_data_ff <= 8'h00;
			load_hit_ff <= 1'b0;
			flash_erase_ff <= 1'b0;
			flash_write_ff <= 1'b0;
			page_select_field_ff <= 8'h00;
			lock_bits_ff <= fspc_pkg::LOCK_RESET;
			ready_irq_ff <= 1'b0;
			cpu_halt_ff <= 1'b0;
			fetch_no_read_while_write_region_only_ff <= 1'b0;
			rw_region_busy_ff <= 1'b0;
			boot_start_ff <= fspc_pkg::BOOT_START_0;
			boot_words_ff <= fspc_pkg::BOOT_WORDS_0;
			flash_buf_data_ff <= 16'h0000;
		end else begin
			irq_en_ff <= nxt_irq_en;
			busy_ff <= nxt_busy;
			cmd_ff <= nxt_cmd;
			win_ff <= nxt_win;
			state_ff <= nxt_state;
			lock_data_ff <= nxt_lock_data;
			io_rdata_ff <= rdata_n;
			load_data_ff <= load_n;
			load_hit_ff <= hit_n;
			flash_erase_ff <= erase_ff_n;
			flash_write_ff <= write_ff_n;
			page_select_field_ff <= page_n;
			lock_bits_ff <= lock_n;
			ready_irq_ff <= irq_n;
			cpu_halt_ff <= halt_n;
			fetch_no_read_while_write_region_only_ff <= fetch_n;
			rw_region_busy_ff <= nxt_busy;
			boot_start_ff <= bstart_n;
			boot_words_ff <= bwords_n;
			flash_buf_data_ff <= cif.buf_rd_data;
		end
	end
endmodule // fspc_ctrl

// >>> core/fspc_pkg.sv
// constants, field positions and types for the flash self-programming controller
package fspc_pkg;
	// control/status register location in the i/o space
	localparam logic [5:0] REG_ADDR = 6'h37;
	localparam logic [7:0] REG_RESET = 8'h00;
	// control/status field positions
	localparam int BIT_IRQ_EN = 7;
	localparam int BIT_BUSY = 6;
	localparam int BIT_RSVD = 5;
	localparam int BIT_READ_EN = 4;
	localparam int BIT_LOCK_SET = 3;
	localparam int BIT_PAGE_WRITE = 2;
	localparam int BIT_PAGE_ERASE = 1;
	localparam int BIT_ENABLE = 0;
	// accepted command patterns in the low five bits
	localparam logic [4:0] PAT_READ_EN = 5'h11;
	localparam logic [4:0] PAT_LOCK_SET = 5'h09;
	localparam logic [4:0] PAT_PAGE_WRITE = 5'h05;
	localparam logic [4:0] PAT_PAGE_ERASE = 5'h03;
	localparam logic [4:0] PAT_FILL = 5'h01;
	// pointer field positions
	localparam int PTR_PAGE_MSB = 14;
	localparam int PTR_PAGE_LSB = 7;
	localparam int PTR_WORD_MSB = 6;
	localparam int PTR_WORD_LSB = 1;
	localparam int PAGE_WORDS = 64;
	localparam int PAGE_BITS = 8;
	localparam int WORD_BITS = 6;
	// region split: pages below this form the read-while-write region
	localparam logic [7:0] RWW_PAGES = 8'hE0;
	// boot section start word addresses per fuse code
	localparam logic [13:0] BOOT_START_3 = 14'h3F00;
	localparam logic [13:0] BOOT_START_2 = 14'h3E00;
	localparam logic [13:0] BOOT_START_1 = 14'h3C00;
	localparam logic [13:0] BOOT_START_0 = 14'h3800;
	localparam logic [11:0] BOOT_WORDS_3 = 12'h100;
	localparam logic [11:0] BOOT_WORDS_2 = 12'h200;
	localparam logic [11:0] BOOT_WORDS_1 = 12'h400;
	localparam logic [11:0] BOOT_WORDS_0 = 12'h800;
	// readback select codes in the low pointer bits
	localparam logic [1:0] SEL_FUSE_LO = 2'h0;
	localparam logic [1:0] SEL_LOCK = 2'h1;
	localparam logic [1:0] SEL_FUSE_EXT = 2'h2;
	localparam logic [1:0] SEL_FUSE_HI = 2'h3;
	localparam logic [7:0] LOCK_RESET = 8'hFF;
	localparam logic [7:0] LOCK_KEEP = 8'hC0;
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int PROG_MIN_NS = 3_700_000;
	localparam int PROG_MAX_NS = 4_500_000;
	localparam int PROG_CYC = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROG_MAX_CYC = PROG_MAX_NS / CLK_PERIOD_NS;
	localparam int TMR_BITS = 17;
	localparam logic [2:0] STORE_WIN = 3'h4;
	localparam logic [2:0] LOAD_WIN = 3'h3;
	// operation sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PROG = 2'b01,
		ST_LOCK = 2'b10
	} fspc_state_type;
endpackage

// >>> core/fspc_core_if.sv
// carrier between the sequencer, its page buffer and its program timer
`timescale 1ns/1ps
interface fspc_core_if;
	// page buffer write, clear and read
	logic buf_wr;
	logic [5:0] buf_wr_addr;
	logic [15:0] buf_wr_data;
	logic buf_clr;
	logic [5:0] buf_rd_addr;
	logic [15:0] buf_rd_data;
	logic buf_loaded;
	// program timer
	logic tmr_start;
	logic tmr_busy;
	logic tmr_done;
	modport ctrl (output buf_wr, buf_wr_addr, buf_wr_data, buf_clr, buf_rd_addr, tmr_start,
		input buf_rd_data, buf_loaded, tmr_busy, tmr_done);
	modport buffer (input buf_wr, buf_wr_addr, buf_wr_data, buf_clr, buf_rd_addr,
		output buf_rd_data, buf_loaded);
	modport timer (input tmr_start, output tmr_busy, tmr_done);
endinterface

// >>> core/fspc_page_buffer.sv
// temporary page buffer filled word by word before a page write
`timescale 1ns/1ps
module fspc_page_buffer #(
	parameter int DEPTH = fspc_pkg::PAGE_WORDS
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// sequencer side
	fspc_core_if.buffer bus
);
	logic [15:0] mem [DEPTH]; // word storage, no reset needed
	logic [15:0] rd_data_ff;
	logic [15:0] nxt_rd_data;
	logic loaded_ff;
	logic nxt_loaded;

	// next values: clear wins so an abort really discards the load
	always_comb begin
		// a discarded or consumed buffer reads as erased, so stale words never leak out
		nxt_rd_data = loaded_ff ? mem[bus.buf_rd_addr] : 16'hFFFF;
		nxt_loaded = loaded_ff;
		if (bus.buf_clr) begin
			nxt_loaded = 1'b0;
		end else if (bus.buf_wr) begin
			nxt_loaded = 1'b1;
		end
	end

	// storage has no reset: the loaded flag decides whether its words are visible
	always_ff @(posedge clk) begin
		if (bus.buf_wr) begin
			mem[bus.buf_wr_addr] <= bus.buf_wr_data;
		end
	end

	// registered read port and load flag
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_ff <= 16'h0000;
			loaded_ff <= 1'b0;
		end else begin
			rd_data_ff <= nxt_rd_data;
			loaded_ff <= nxt_loaded;
		end
	end

	assign bus.buf_rd_data = rd_data_ff;
	assign bus.buf_loaded = loaded_ff;
endmodule // fspc_page_buffer

// >>> core/fspc_prog_timer.sv
// program timer counting one erase, write or lock operation
`timescale 1ns/1ps
module fspc_prog_timer #(
	parameter int CYCLES = fspc_pkg::PROG_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// sequencer side
	fspc_core_if.timer bus
);
	logic [fspc_pkg::TMR_BITS-1:0] cnt_ff;
	logic [fspc_pkg::TMR_BITS-1:0] nxt_cnt;
	logic done_ff;
	logic nxt_done;

	// count down from the start; done pulses on the last cycle
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_done = 1'b0;
		if (bus.tmr_start && cnt_ff == '0) begin
			nxt_cnt = fspc_pkg::TMR_BITS'(CYCLES);
		end else if (cnt_ff != '0) begin
			nxt_cnt = cnt_ff - 1'b1;
			nxt_done = (cnt_ff == fspc_pkg::TMR_BITS'(1));
		end
	end

	// counter registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_ff <= '0;
			done_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			done_ff <= nxt_done;
		end
	end

	assign bus.tmr_busy = (cnt_ff != '0);
	assign bus.tmr_done = done_ff;
endmodule // fspc_prog_timer

// >>> dv/fspc_ctrl_asserts.sv
// concurrent checks on the ports of the self-programming controller
`timescale 1ns/1ps
module fspc_ctrl_asserts #(
	parameter int PROG_CYCLES = 20
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// watched ports
	input wire logic io_rd,
	input wire logic [5:0] io_addr,
	input wire logic [7:0] io_rdata_ff,
	input wire logic global_irq_en,
	input wire logic ready_irq_ff,
	input wire logic load_exec,
	input wire logic load_hit_ff,
	input wire logic flash_erase_ff,
	input wire logic flash_write_ff,
	input wire logic [7:0] page_select_field_ff,
	input wire logic fetch_no_read_while_write_region_only_ff,
	input wire logic cpu_halt_ff,
	input wire logic rw_region_busy_ff,
	input wire logic [13:0] boot_start_ff,
	input wire logic [11:0] boot_words_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// cycles of the current operation; wide enough for the full-length count
	logic [16:0] cnt_ff;
	logic [16:0] nxt_cnt;
	// count while the fetch restriction stands
	always_comb begin
		nxt_cnt = fetch_no_read_while_write_region_only_ff ? cnt_ff + 17'h0_0001 : 17'h0_0000;
	end
	// register the count
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_ff <= 17'h0_0000;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
	AST_OP_LEN: assert property ($fell(fetch_no_read_while_write_region_only_ff) |-> cnt_ff == 17'(PROG_CYCLES + 1))
		else $error("operation length wrong");
	AST_BOOT: assert property (({1'b0, boot_start_ff} + {3'h0, boot_words_ff}) == 15'h4000)
		else $error("boot start and size disagree");
	AST_RSVD: assert property (io_rdata_ff[5] == 1'b0)
		else $error("reserved bit read as one");
	AST_RDATA: assert property (!$past(io_rd && io_addr == fspc_pkg::REG_ADDR) |-> io_rdata_ff == 8'h00)
		else $error("read data without a read");
	AST_IRQ: assert property (($past(!global_irq_en) || fetch_no_read_while_write_region_only_ff) |-> !ready_irq_ff)
		else $error("ready interrupt while blocked");
	AST_REGION: assert property ($rose(fetch_no_read_while_write_region_only_ff) |->
		((page_select_field_ff < 8'hE0) ? rw_region_busy_ff : cpu_halt_ff))
		else $error("busy or halt missing at start");
	AST_PULSE: assert property ((flash_erase_ff || flash_write_ff) |=>
		!(flash_erase_ff || flash_write_ff) && fetch_no_read_while_write_region_only_ff)
		else $error("start pulse wrong");
	AST_HALT: assert property (cpu_halt_ff |-> fetch_no_read_while_write_region_only_ff)
		else $error("halt outside an operation");
	AST_LOAD: assert property (load_hit_ff |-> $past(load_exec))
		else $error("load answer without load");
endmodule // fspc_ctrl_asserts

// >>> dv/fspc_cpu_model.sv
// behavioural cpu issuing timed register writes and store/load instructions
`timescale 1ns/1ps
module fspc_cpu_model (
	// clock
	input wire logic clk,
	// register access
	output logic io_wr,
	output logic io_rd,
	output logic [5:0] io_addr,
	output logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata_ff,
	// store and load instructions
	output logic store_exec,
	output logic load_exec,
	output logic [15:0] z_ptr,
	output logic [7:0] r0_data,
	output logic [7:0] r1_data,
	input wire logic [7:0] load_data_ff,
	input wire logic load_hit_ff
);
	// idle values at time zero
	initial begin
		{io_wr, io_rd, store_exec, load_exec} = 4'h0;
		{io_addr, io_wdata, z_ptr, r0_data, r1_data} = '0;
	end
	// each task is entered at a falling edge and leaves at one
	task automatic wr(input logic [7:0] d);
		io_wr = 1'b1;
		io_addr = fspc_pkg::REG_ADDR;
		io_wdata = d;
		@(negedge clk);
		io_wr = 1'b0;
		io_wdata = ~io_wdata;
	endtask
	task automatic rd(output logic [7:0] d);
		io_rd = 1'b1;
		io_addr = fspc_pkg::REG_ADDR;
		@(negedge clk);
		io_rd = 1'b0;
		d = io_rdata_ff;
	endtask
	// released operands flip so a stale value is never mistaken for a held one
	task automatic spm(input logic [15:0] z, input logic [7:0] r1, input logic [7:0] r0);
		store_exec = 1'b1;
		z_ptr = z & 16'hFFFE;
		r1_data = r1;
		r0_data = r0;
		@(negedge clk);
		store_exec = 1'b0;
		z_ptr = ~z_ptr;
		r1_data = ~r1_data;
		r0_data = ~r0_data;
	endtask
	task automatic lpm(input logic [15:0] z, output logic [7:0] d);
		load_exec = 1'b1;
		z_ptr = z;
		@(negedge clk);
		load_exec = 1'b0;
		for (int i = 0; i < 3 && load_hit_ff !== 1'b1; i++) @(negedge clk);
		d = load_data_ff;
	endtask
endmodule // fspc_cpu_model

// >>> dv/tb_fspc_ctrl.sv
// self-checking bench for the flash self-programming controller
`timescale 1ns/1ps
module tb_fspc_ctrl;
	// clock, reset and bench-driven inputs
	logic clk;
	logic rst_b;
	logic global_irq_en;
	logic [1:0] boot_size_fuse;
	logic [7:0] fuse_lo;
	logic [7:0] fuse_hi;
	logic [7:0] fuse_ext;
	logic eeprom_write_active;
	logic [5:0] flash_buf_addr;
	// cpu-driven inputs and design outputs
	logic io_wr, io_rd, store_exec, load_exec, load_hit_ff, flash_erase_ff, flash_write_ff;
	logic ready_irq_ff, cpu_halt_ff, fetch_no_read_while_write_region_only_ff, rw_region_busy_ff;
	logic [5:0] io_addr;
	logic [7:0] io_wdata, r0_data, r1_data, io_rdata_ff, load_data_ff, page_select_field_ff, lock_bits_ff, v;
	logic [15:0] z_ptr, flash_buf_data_ff;
	logic [13:0] boot_start_ff;
	logic [11:0] boot_words_ff;
	logic [7:0] bad [4] = '{8'hE7, 8'h8F, 8'h9F, 8'h8B};
	logic [7:0] exp_rd [4];
	int num_errors = 0;
	int compares = 0;
	int n_ers = 0;
	int n_wr = 0;
	// short operation so a run stays brief
	fspc_ctrl #(.PROG_CYCLES(20)) u_fspc_ctrl (.clk, .rst_b, .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata_ff,
		.store_exec, .load_exec, .z_ptr, .r0_data, .r1_data, .global_irq_en, .load_data_ff, .load_hit_ff,
		.boot_size_fuse, .fuse_lo, .fuse_hi, .fuse_ext, .eeprom_write_active, .flash_buf_addr,
		.flash_buf_data_ff, .flash_erase_ff, .flash_write_ff, .page_select_field_ff, .lock_bits_ff,
		.ready_irq_ff, .cpu_halt_ff, .fetch_no_read_while_write_region_only_ff, .rw_region_busy_ff, .boot_start_ff, .boot_words_ff);
	fspc_cpu_model u_fspc_cpu_model (.clk, .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata_ff, .store_exec,
		.load_exec, .z_ptr, .r0_data, .r1_data, .load_data_ff, .load_hit_ff);
	// 100 ns clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// count start pulses away from the launching edge
	always @(negedge clk) begin
		if (flash_erase_ff === 1'b1) n_ers++;
		if (flash_write_ff === 1'b1) n_wr++;
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// poll the enable bit; bounded so a stuck operation shows as a mismatch
	task automatic idle();
		u_fspc_cpu_model.rd(v);
		// one idle edge between polls so the read strobe really drops
		for (int i = 0; i < 60 && v[0] !== 1'b0; i++) begin
			@(negedge clk);
			u_fspc_cpu_model.rd(v);
		end
		chk("idle", 16'h0000, {15'h0, v[0]});
	endtask
	// armed erase or write on a page, with junk operands that must be ignored
	task automatic op(input logic [7:0] cmd, input logic [7:0] pg);
		u_fspc_cpu_model.wr(cmd);
		u_fspc_cpu_model.spm({1'b1, pg, 7'h00}, 8'hA5, 8'h5A);
		@(negedge clk);
	endtask
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// watchdog well beyond the expected run of under two hundred cycles
	initial begin
		repeat (3000) @(posedge clk);
		num_errors++;
		$display("watchdog expired");
		test_done();
	end
	// test sequence
	initial begin
		rst_b = 1'b0;
		global_irq_en = 1'b0;
		boot_size_fuse = 2'h0;
		{fuse_lo, fuse_hi, fuse_ext} = 24'h5A_C3F6;
		eeprom_write_active = 1'b0;
		flash_buf_addr = 6'h00;
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		u_fspc_cpu_model.rd(v);
		chk("reg", 8'h00, v);
		chk("lock", 8'hFF, lock_bits_ff);
		for (int f = 0; f < 4; f++) begin
			boot_size_fuse = f[1:0];
			repeat (2) @(negedge clk);
			chk("boot", 16'h4000 - (16'h0800 >> f), {2'h0, boot_start_ff});
			chk("words", 16'h0800 >> f, {4'h0, boot_words_ff});
		end
		$display("test reset done");
		global_irq_en = 1'b1;
		op(8'h83, 8'h05);
		chk("busy", 1'b1, rw_region_busy_ff);
		chk("fetch", 1'b1, fetch_no_read_while_write_region_only_ff);
		chk("page", 8'h05, page_select_field_ff);
		chk("irq", 1'b0, ready_irq_ff);
		u_fspc_cpu_model.rd(v);
		chk("run", 8'hC3, v);
		u_fspc_cpu_model.wr(8'h91);
		u_fspc_cpu_model.spm(16'h0000, 8'h00, 8'h00);
		idle();
		chk("irq", 1'b1, ready_irq_ff);
		chk("keep", 1'b1, rw_region_busy_ff);
		u_fspc_cpu_model.wr(8'h91);
		u_fspc_cpu_model.spm(16'h0000, 8'h00, 8'h00);
		@(negedge clk);
		chk("rwe", 1'b0, rw_region_busy_ff);
		$display("test erase done");
		op(8'h83, 8'h06);
		idle();
		u_fspc_cpu_model.wr(8'h81);
		u_fspc_cpu_model.spm(16'h0006, 8'hBE, 8'hEF);
		@(negedge clk);
		chk("fill", 1'b0, rw_region_busy_ff);
		flash_buf_addr = 6'h03;
		repeat (3) @(negedge clk);
		chk("buf", 16'hBEEF, flash_buf_data_ff);
		op(8'h85, 8'hE2);
		chk("halt", 1'b1, cpu_halt_ff);
		chk("page", 8'hE2, page_select_field_ff);
		idle();
		// fill one word, then read-enable while loaded must discard it
		u_fspc_cpu_model.wr(8'h81);
		u_fspc_cpu_model.spm(16'h0006, 8'h12, 8'h34);
		u_fspc_cpu_model.wr(8'h91);
		repeat (3) @(negedge clk);
		chk("abort", 16'hFFFF, flash_buf_data_ff);
		$display("test write done");
		u_fspc_cpu_model.wr(8'h85);
		repeat (5) @(negedge clk);
		u_fspc_cpu_model.spm(16'h0000, 8'h00, 8'h00);
		u_fspc_cpu_model.rd(v);
		chk("expire", 8'h80, v);
		foreach (bad[i]) begin
			u_fspc_cpu_model.wr(bad[i]);
			u_fspc_cpu_model.rd(v);
			chk("ignore", 8'h80, v);
		end
		eeprom_write_active = 1'b1;
		u_fspc_cpu_model.wr(8'h83);
		u_fspc_cpu_model.rd(v);
		eeprom_write_active = 1'b0;
		chk("eeprom", 8'h80, v);
		global_irq_en = 1'b0;
		repeat (2) @(negedge clk);
		chk("irq", 1'b0, ready_irq_ff);
		$display("test refuse done");
		u_fspc_cpu_model.wr(8'h89);
		u_fspc_cpu_model.spm(16'h0000, 8'h00, 8'hF0);
		idle();
		chk("lock", 8'hF0, lock_bits_ff);
		{fuse_lo, fuse_hi, fuse_ext} = 24'hA5_3C09;
		exp_rd = '{fuse_lo, 8'hF0, fuse_ext, fuse_hi};
		for (int z = 0; z < 4; z++) begin
			u_fspc_cpu_model.wr(8'h89);
			u_fspc_cpu_model.lpm(z[15:0], v);
			chk("hit", 16'h0001, {15'h0, load_hit_ff});
			chk("rdbk", exp_rd[z], v);
		end
		// a load on the fourth edge is outside the window
		u_fspc_cpu_model.wr(8'h89);
		repeat (3) @(negedge clk);
		u_fspc_cpu_model.lpm(16'h0001, v);
		chk("late", 16'h0000, {15'h0, load_hit_ff});
		$display("test lock done");
		// reset in the middle of an erase must leave everything idle
		op(8'h83, 8'h08);
		rst_b = 1'b0;
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		u_fspc_cpu_model.rd(v);
		chk("reg", 8'h00, v);
		chk("busy", 1'b0, rw_region_busy_ff);
		chk("fetch", 1'b0, fetch_no_read_while_write_region_only_ff);
		chk("erases", 16'h0003, n_ers[15:0]);
		chk("writes", 16'h0001, n_wr[15:0]);
		$display("test midrun reset done");
		test_done();
	end
endmodule // tb_fspc_ctrl
bind fspc_ctrl fspc_ctrl_asserts #(.PROG_CYCLES(PROG_CYCLES)) u_fspc_ctrl_asserts (.clk, .rst_b, .io_rd,
	.io_addr, .io_rdata_ff, .global_irq_en, .ready_irq_ff, .load_exec, .load_hit_ff, .flash_erase_ff,
	.flash_write_ff, .page_select_field_ff, .fetch_no_read_while_write_region_only_ff, .cpu_halt_ff, .rw_region_busy_ff,
	.boot_start_ff, .boot_words_ff);
